// file: usbcs_pkg.sv
// Constants and types for the USB core control and status register block.
// Assumes a 32-bit APB master and a USB engine that runs on the same clock.
// Function
// - Endpoint 1-7 transmit event flags live in bits 23 down to 17.
// - Endpoint zero event flag in bit 16 is set while an event awaits service.
// - Reading the flag byte clears those flags; software reads that byte alone.
// - Device iso endpoint with bit 15 set holds a ready packet until next SOF.
// - Device soft connect bit 14 enables the D+/D- lines; clear tri-states them.
// - High-speed enable bit 13 allows high-speed negotiation; clear means full speed only.
// - Bit 12 reports high speed, valid after device bus reset or host reset clear.
// - Bit 11 reads bus reset signaling; read-only in device, read/write in host.
// - Host toggle bit 25 reads current toggle; writes only count with bit 26 set.
// - Bit 24 flags an incomplete iso packet and reads 0 for other types, cleared by writing 0.
// - Writing 1 to bit 23 clears the data toggle; 0 leaves it alone.
// - Device bit 22 sets after a STALL is sent, stays until written 0.
// - Host bit 22 sets with an interrupt on a received STALL, cleared by 0.
// - Device bit 21 makes the endpoint answer STALL; clearing ends the stall.
// - Host bit 21 requests an IN transaction, cleared when a packet becomes ready.
// - Flush bit 20 drops the next packet, clears packet ready and self-clears.
// - Device bit 19 flags iso CRC/stuff error, clears with packet ready, bulk reads 0.
// - Host bit 19 flags CRC/stuff error, and NAK time-out for bulk endpoints.
package usbcs_pkg;

  // ==========================================================================
  // Register map
  localparam int         APB_AW      = 8;
  localparam logic [7:0] ADDR_GLOBAL = 8'h00;
  localparam logic [7:0] ADDR_EP     = 8'h04;
  localparam logic [7:0] ADDR_CFG    = 8'h08;
  localparam logic [7:0] ADDR_IST    = 8'h0c;
  localparam logic [7:0] ADDR_IMSK   = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int GB_EPTX_MSB = 23;
  localparam int GB_EPTX_LSB = 17;
  localparam int GB_EP0      = 16;
  localparam int GB_ISO      = 15;
  localparam int GB_SOFTC    = 14;
  localparam int GB_HIGH_SPEED_ENABLE     = 13;
  localparam int GB_HSST     = 12;
  localparam int GB_RESET    = 11;
  localparam int EP_TWEN     = 26;
  localparam int EP_TGL      = 25;
  localparam int EP_INC      = 24;
  localparam int EP_CLEAR_DATA_TOGGLE    = 23;
  localparam int EP_STST     = 22;
  localparam int EP_STRQ     = 21;
  localparam int EP_FLUSH    = 20;
  localparam int EP_DERR     = 19;
  localparam int EP_RXRDY    = 16;
  localparam int CF_HOST     = 0;
  localparam int CF_TYPE_LSB = 1;
  localparam int CF_TYPE_MSB = 2;
  localparam int IRQ_W       = 5;
  localparam int IQ_TX       = 0;
  localparam int IQ_EP0      = 1;
  localparam int IQ_STALL    = 2;
  localparam int IQ_RXRDY    = 3;
  localparam int IQ_RXERR    = 4;

  // Endpoint transfer type encoding.
  localparam logic [1:0] TYPE_CTRL = 2'h0;
  localparam logic [1:0] TYPE_ISO  = 2'h1;
  localparam logic [1:0] TYPE_BULK = 2'h2;
  localparam logic [1:0] TYPE_INTR = 2'h3;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [6:0] tx_ep_evt;     // Per endpoint 1-7 transmit event pulses.
    logic       ep0_evt;       // Control endpoint event pulse.
    logic       sof;           // Start-of-frame token seen.
    logic       tx_rdy;        // Transmit packet ready marked.
    logic       hs_ok;         // High-speed handshake succeeded.
    logic       stall_sent;    // STALL handshake transmitted.
    logic       stall_rcvd;    // STALL handshake received.
    logic       rx_rdy;        // Receive packet ready.
    logic       rx_incomplete; // High-bandwidth packet lacks data.
    logic       rx_crc_err;    // CRC or bit-stuff error.
    logic       nak_timeout;   // NAK limit exceeded.
    logic       toggle_adv;    // Engine advanced the data toggle.
  } usbcs_evt_t;

  typedef struct packed {
    logic line_oe;     // Drive D+/D-.
    logic hs_enable;   // Allow high-speed chirp.
    logic drive_reset; // Host drives bus reset.
    logic stall_hs;    // Answer with STALL.
    logic in_request;  // Host IN transaction wanted.
    logic fifo_flush;  // One-cycle FIFO flush.
    logic tx_go;       // One-cycle packet release.
    logic data_toggle; // Current data toggle.
  } usbcs_ctl_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    usbcs_ctl_t  ctl;
    logic [6:0]  eptx;
    logic        ep0;
    logic        iso_wait;
    logic        soft_conn;
    logic        hs_en;
    logic        hs_stat;
    logic        host_rst;
    logic        bus_rst_q;
    logic        twen;
    logic        incomp;
    logic        stall_st;
    logic        stall_rq;
    logic        in_req;
    logic        derr;
    logic        rxrdy;
    logic        tx_pend;
    logic        host;
    logic [1:0]  eptype;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imask;
  } usbcs_state_t;

  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic q;
  } usbcs_sync_t;

  // High-speed enable resets to one.
  localparam usbcs_ctl_t   CTL_RST   = '{hs_enable: 1'b1, default: 1'b0};
  localparam usbcs_state_t STATE_RST = '{hs_en: 1'b1, ctl: CTL_RST, default: '0};

endpackage

// file: usbcs_sync.sv
// Three-stage synchroniser with agreement filter for a pin input.
// Assumes the input is asynchronous to clock_i.
`timescale 1ns/1ns
module usbcs_sync (
  input  wire logic clock_i, // Core clock.
  input  wire logic rst_i,   // Asynchronous reset, active high.
  input  wire logic d_i,     // Raw pin level.
  output logic      q_o      // Filtered level.
);

  usbcs_pkg::usbcs_sync_t s;
  usbcs_pkg::usbcs_sync_t n;

  // ==========================================================================
  // Next state
  // The output moves only when the second and third stages agree.
  always_comb begin
    n    = s;
    n.f1 = d_i;
    n.f2 = s.f1;
    n.f3 = s.f2;
    if (s.f2 == s.f3) begin
      n.q = s.f3;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign q_o = s.q;

endmodule // usbcs_sync

// file: usbcs_top.sv
// USB core control and status registers with an APB slave and one interrupt.
// Assumes the USB engine shares clock_i and gives one-cycle event pulses.
`timescale 1ns/1ns
module usbcs_top (
  input  wire logic                  clock_i,        // 250 MHz core clock.
  input  wire logic                  rst_i,          // Asynchronous reset, active high.
  input  wire logic                  psel_i,         // APB select.
  input  wire logic                  penable_i,      // APB enable.
  input  wire logic                  pwrite_i,       // APB direction.
  input  wire logic [7:0]            paddr_i,        // APB byte address.
  input  wire logic [31:0]           pwdata_i,       // APB write data.
  output logic      [31:0]           prdata_o,       // APB read data.
  output logic                       pready_o,       // APB ready.
  output logic                       pslverr_o,      // APB error on unmapped address.
  input  wire logic                  bus_rst_line_i, // Reset signaling seen on the bus.
  input  wire usbcs_pkg::usbcs_evt_t evt_i,          // Engine events.
  output usbcs_pkg::usbcs_ctl_t      ctl_o,          // Controls to the engine and PHY.
  output logic                       irq_o           // Level interrupt.
);

  usbcs_pkg::usbcs_state_t s;
  usbcs_pkg::usbcs_state_t n;
  logic                    rst_line;
  logic                    setup;
  logic                    acc;
  logic                    wr_glb;
  logic                    wr_ep;
  logic                    rd_glb;
  logic                    is_iso;
  logic                    is_bulk;
  logic                    hs_cap;
  logic [usbcs_pkg::IRQ_W-1:0] ev;

  // ==========================================================================
  // Decode helpers
  function automatic logic mapped(input logic [7:0] a);
    return (a == usbcs_pkg::ADDR_GLOBAL) || (a == usbcs_pkg::ADDR_EP) ||
           (a == usbcs_pkg::ADDR_CFG) || (a == usbcs_pkg::ADDR_IST) ||
           (a == usbcs_pkg::ADDR_IMSK);
  endfunction

  function automatic logic [31:0] rd_word(input usbcs_pkg::usbcs_state_t st,
                                          input logic rl, input logic [7:0] a);
    logic [31:0] w;
    logic        iso;
    logic        bulk;
    w    = '0;
    iso  = st.eptype == usbcs_pkg::TYPE_ISO;
    bulk = st.eptype == usbcs_pkg::TYPE_BULK;
    case (a)
      usbcs_pkg::ADDR_GLOBAL: begin
        w[usbcs_pkg::GB_EPTX_MSB:usbcs_pkg::GB_EPTX_LSB] = st.eptx;
        w[usbcs_pkg::GB_EP0]   = st.ep0;
        w[usbcs_pkg::GB_ISO]   = st.iso_wait & ~st.host;
        w[usbcs_pkg::GB_SOFTC] = st.soft_conn;
        w[usbcs_pkg::GB_HIGH_SPEED_ENABLE]  = st.hs_en;
        w[usbcs_pkg::GB_HSST]  = st.hs_stat;
        w[usbcs_pkg::GB_RESET] = st.host ? st.host_rst : rl;
      end
      usbcs_pkg::ADDR_EP: begin
        w[usbcs_pkg::EP_TWEN]  = st.twen;
        w[usbcs_pkg::EP_TGL]   = st.ctl.data_toggle;
        w[usbcs_pkg::EP_INC]   = st.incomp & iso;
        w[usbcs_pkg::EP_STST]  = st.stall_st;
        w[usbcs_pkg::EP_STRQ]  = st.host ? st.in_req : st.stall_rq;
        w[usbcs_pkg::EP_DERR]  = st.derr & (st.host | ~bulk);
        w[usbcs_pkg::EP_RXRDY] = st.rxrdy;
      end
      usbcs_pkg::ADDR_CFG: begin
        w[usbcs_pkg::CF_HOST] = st.host;
        w[usbcs_pkg::CF_TYPE_MSB:usbcs_pkg::CF_TYPE_LSB] = st.eptype;
      end
      usbcs_pkg::ADDR_IST: begin
        w[usbcs_pkg::IRQ_W-1:0] = st.ist;
      end
      usbcs_pkg::ADDR_IMSK: begin
        w[usbcs_pkg::IRQ_W-1:0] = st.imask;
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  // ==========================================================================
  // Bus reset line synchroniser
  usbcs_sync u_rst_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     (bus_rst_line_i),
    .q_o     (rst_line)
  );

  // ==========================================================================
  // Bus strobes
  // Read data is captured in the setup cycle, so the slave answers with
  // pready in the first access cycle and never inserts wait states.
  assign setup   = psel_i & ~penable_i;
  assign acc     = psel_i & penable_i & s.pready;
  assign wr_glb  = acc & pwrite_i & (paddr_i == usbcs_pkg::ADDR_GLOBAL);
  assign wr_ep   = acc & pwrite_i & (paddr_i == usbcs_pkg::ADDR_EP);
  assign rd_glb  = acc & ~pwrite_i & (paddr_i == usbcs_pkg::ADDR_GLOBAL);
  assign is_iso  = s.eptype == usbcs_pkg::TYPE_ISO;
  assign is_bulk = s.eptype == usbcs_pkg::TYPE_BULK;
  assign hs_cap  = evt_i.hs_ok & s.hs_en;

  // ==========================================================================
  // Next state
  always_comb begin
    n                = s;
    n.pready         = 1'b0;
    n.pslverr        = 1'b0;
    n.prdata         = '0;
    n.ctl.fifo_flush = 1'b0;
    n.ctl.tx_go      = 1'b0;
    ev               = '0;
    if (setup) begin
      n.pready  = 1'b1;
      n.pslverr = ~mapped(paddr_i);
      if (!pwrite_i) begin
        n.prdata = rd_word(s, rst_line, paddr_i);
      end
    end

    // Only the bits that went out on the bus are cleared, so an event that
    // lands between capture and completion survives the read.
    if (rd_glb) begin
      n.eptx = s.eptx & ~s.prdata[usbcs_pkg::GB_EPTX_MSB:usbcs_pkg::GB_EPTX_LSB];
      n.ep0  = s.ep0 & ~s.prdata[usbcs_pkg::GB_EP0];
    end
    n.eptx = n.eptx | evt_i.tx_ep_evt;
    n.ep0  = n.ep0 | evt_i.ep0_evt;

    if (wr_glb) begin
      n.iso_wait  = pwdata_i[usbcs_pkg::GB_ISO] & ~s.host;
      n.soft_conn = pwdata_i[usbcs_pkg::GB_SOFTC];
      n.hs_en     = pwdata_i[usbcs_pkg::GB_HIGH_SPEED_ENABLE];
      if (s.host) begin
        n.host_rst = pwdata_i[usbcs_pkg::GB_RESET];
      end
    end
    if (acc && pwrite_i && paddr_i == usbcs_pkg::ADDR_CFG) begin
      n.host   = pwdata_i[usbcs_pkg::CF_HOST];
      n.eptype = pwdata_i[usbcs_pkg::CF_TYPE_MSB:usbcs_pkg::CF_TYPE_LSB];
    end
    n.host_rst = n.host_rst & n.host;

    // Speed status is latched at the end of reset in either role.
    if (!s.host && s.bus_rst_q && !rst_line) begin
      n.hs_stat = hs_cap;
    end
    if (s.host && s.host_rst && !n.host_rst) begin
      n.hs_stat = hs_cap;
    end
    n.bus_rst_q = rst_line;

    // Iso packets wait for the frame start when asked to.
    if (s.tx_pend && (!(s.iso_wait && !s.host && is_iso) || evt_i.sof)) begin
      n.tx_pend   = 1'b0;
      n.ctl.tx_go = 1'b1;
    end
    if (evt_i.tx_rdy) begin
      n.tx_pend = 1'b1;
    end

    if (evt_i.toggle_adv) begin
      n.ctl.data_toggle = ~s.ctl.data_toggle;
    end
    if (wr_ep) begin
      n.twen = pwdata_i[usbcs_pkg::EP_TWEN];
      if (s.host && pwdata_i[usbcs_pkg::EP_TWEN]) begin
        n.ctl.data_toggle = pwdata_i[usbcs_pkg::EP_TGL];
      end
      if (pwdata_i[usbcs_pkg::EP_CLEAR_DATA_TOGGLE]) begin
        n.ctl.data_toggle = 1'b0;
      end
      if (!pwdata_i[usbcs_pkg::EP_INC]) begin
        n.incomp = 1'b0;
      end
      if (!pwdata_i[usbcs_pkg::EP_STST]) begin
        n.stall_st = 1'b0;
      end
      if (s.host) begin
        n.in_req = pwdata_i[usbcs_pkg::EP_STRQ];
      end else begin
        n.stall_rq = pwdata_i[usbcs_pkg::EP_STRQ];
      end
      if (!pwdata_i[usbcs_pkg::EP_RXRDY]) begin
        n.rxrdy = 1'b0;
      end
      if (pwdata_i[usbcs_pkg::EP_FLUSH]) begin
        n.rxrdy          = 1'b0;
        n.ctl.fifo_flush = 1'b1;
      end
    end

    if (evt_i.rx_incomplete && (is_iso || s.eptype == usbcs_pkg::TYPE_INTR)) begin
      n.incomp = 1'b1;
    end
    if ((!s.host && evt_i.stall_sent) || (s.host && evt_i.stall_rcvd)) begin
      n.stall_st         = 1'b1;
      ev[usbcs_pkg::IQ_STALL] = 1'b1;
    end
    if (evt_i.rx_rdy) begin
      n.rxrdy                 = 1'b1;
      n.in_req                = 1'b0;
      ev[usbcs_pkg::IQ_RXRDY] = 1'b1;
    end

    // The error flag follows the packet it describes.
    if (s.rxrdy && !n.rxrdy) begin
      n.derr = 1'b0;
    end
    if ((!s.host && evt_i.rx_crc_err && is_iso) ||
        (s.host && (evt_i.rx_crc_err || (evt_i.nak_timeout && is_bulk)))) begin
      n.derr                  = 1'b1;
      ev[usbcs_pkg::IQ_RXERR] = 1'b1;
    end

    ev[usbcs_pkg::IQ_TX]  = |evt_i.tx_ep_evt;
    ev[usbcs_pkg::IQ_EP0] = evt_i.ep0_evt;
    if (acc && pwrite_i && paddr_i == usbcs_pkg::ADDR_IST) begin
      n.ist = s.ist & ~pwdata_i[usbcs_pkg::IRQ_W-1:0];
    end
    n.ist = n.ist | ev;
    if (acc && pwrite_i && paddr_i == usbcs_pkg::ADDR_IMSK) begin
      n.imask = pwdata_i[usbcs_pkg::IRQ_W-1:0];
    end
    n.irq = |(n.ist & n.imask);

    n.ctl.line_oe     = n.soft_conn & ~n.host;
    n.ctl.hs_enable   = n.hs_en;
    n.ctl.drive_reset = n.host_rst;
    n.ctl.stall_hs    = n.stall_rq & ~n.host;
    n.ctl.in_request  = n.in_req & n.host;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s <= usbcs_pkg::STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata_o  = s.prdata;
  assign pready_o  = s.pready;
  assign pslverr_o = s.pslverr;
  assign ctl_o     = s.ctl;
  assign irq_o     = s.irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_tx_flag_set;
    evt_i.tx_ep_evt[0] |=> s.eptx[0];
  endproperty
  a_tx_flag_set: assert property (p_tx_flag_set) else $error("tx flag not set");

  property p_ep0_set;
    evt_i.ep0_evt |=> s.ep0 ##1 (s.ep0 || $past(rd_glb));
  endproperty
  a_ep0_set: assert property (p_ep0_set) else $error("ep0 flag not held");

  property p_rd_clear;
    (rd_glb && s.prdata[usbcs_pkg::GB_EP0] && !evt_i.ep0_evt) |=> !s.ep0;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("ep0 flag survived read");

  property p_iso_hold;
    (s.tx_pend && s.iso_wait && !s.host && is_iso && !evt_i.sof) |=> !ctl_o.tx_go;
  endproperty
  a_iso_hold: assert property (p_iso_hold) else $error("iso packet released early");

  property p_soft_conn;
    (wr_glb && pwdata_i[usbcs_pkg::GB_SOFTC] && !s.host) |=> ctl_o.line_oe;
  endproperty
  a_soft_conn: assert property (p_soft_conn) else $error("lines not enabled");

  property p_hs_stat;
    (!s.host && s.bus_rst_q && !rst_line) |=> (s.hs_stat == $past(hs_cap));
  endproperty
  a_hs_stat: assert property (p_hs_stat) else $error("speed status wrong");

  property p_clr_toggle;
    (wr_ep && pwdata_i[usbcs_pkg::EP_CLEAR_DATA_TOGGLE]) |=> !ctl_o.data_toggle;
  endproperty
  a_clr_toggle: assert property (p_clr_toggle) else $error("toggle not cleared");

  property p_in_req_clr;
    (s.host && evt_i.rx_rdy) |=> !ctl_o.in_request;
  endproperty
  a_in_req_clr: assert property (p_in_req_clr) else $error("IN request not cleared");

  sequence s_flush_pulse;
    (ctl_o.fifo_flush && !s.rxrdy) ##1 !ctl_o.fifo_flush;
  endsequence

  property p_flush;
    (wr_ep && pwdata_i[usbcs_pkg::EP_FLUSH] && !evt_i.rx_rdy) |=> s_flush_pulse;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not a single pulse");

  property p_stall_flag;
    ((!s.host && evt_i.stall_sent) || (s.host && evt_i.stall_rcvd))
      |=> (s.stall_st && s.ist[usbcs_pkg::IQ_STALL]);
  endproperty
  a_stall_flag: assert property (p_stall_flag) else $error("stall status not set");

  property p_toggle_locked;
    (wr_ep && s.host && !pwdata_i[usbcs_pkg::EP_TWEN] && !pwdata_i[usbcs_pkg::EP_CLEAR_DATA_TOGGLE] && !evt_i.toggle_adv)
      |=> $stable(ctl_o.data_toggle);
  endproperty
  a_toggle_locked: assert property (p_toggle_locked) else $error("toggle written while locked");

  property p_host_reset;
    (wr_glb && s.host) |=> (ctl_o.drive_reset == $past(pwdata_i[usbcs_pkg::GB_RESET]));
  endproperty
  a_host_reset: assert property (p_host_reset) else $error("bus reset drive wrong");

  property p_line_off;
    (wr_glb && !pwdata_i[usbcs_pkg::GB_SOFTC]) |=> !ctl_o.line_oe;
  endproperty
  a_line_off: assert property (p_line_off) else $error("lines still driven");

  property p_stall_hs;
    (wr_ep && !s.host) |=> (ctl_o.stall_hs == $past(pwdata_i[usbcs_pkg::EP_STRQ]));
  endproperty
  a_stall_hs: assert property (p_stall_hs) else $error("stall handshake control wrong");

  property p_hs_enable;
    wr_glb |=> (ctl_o.hs_enable == $past(pwdata_i[usbcs_pkg::GB_HIGH_SPEED_ENABLE]));
  endproperty
  a_hs_enable: assert property (p_hs_enable) else $error("high-speed enable wrong");

endmodule // usbcs_top

// file: usbcs_engine_model.sv
// Behavioural USB engine that sits beside the control block and replays bench events.
// Assumes it shares clock_i with the block and that events are one-cycle pulses.
`timescale 1ns/1ns
module usbcs_engine_model (
  input  wire logic                  clock_i, // Core clock.
  input  wire logic                  rst_i,   // Asynchronous reset, active high.
  input  wire usbcs_pkg::usbcs_evt_t fire_i,  // Events requested by the bench.
  input  wire logic [3:0]            lat_i,   // Cycles until an IN request is answered.
  input  wire usbcs_pkg::usbcs_ctl_t ctl_i,   // Controls from the block.
  output usbcs_pkg::usbcs_evt_t      evt_o    // Events to the block.
);
  logic [3:0] wait_ff;
  logic       busy_ff;

  // ====================
  // Engine
  // Busy stays set until the request drops, so one request gets at most one packet, and none when lat_i is zero.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      evt_o <= '0;
      wait_ff <= 4'h0;
      busy_ff <= 1'b0;
    end else begin
      evt_o <= fire_i;
      if (!ctl_i.in_request) begin
        busy_ff <= 1'b0;
      end else if (!busy_ff) begin
        busy_ff <= 1'b1;
        wait_ff <= lat_i;
      end else if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
        if (wait_ff == 4'h1) begin
          evt_o.rx_rdy <= 1'b1;
        end
      end
    end
  end
endmodule // usbcs_engine_model

// file: testbench.sv
// Self-checking bench for the USB control and status block over APB.
// Assumes the engine model on evt_i and one 250 MHz clock.
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] G  = usbcs_pkg::ADDR_GLOBAL;
  localparam logic [7:0] EP = usbcs_pkg::ADDR_EP;
  localparam logic [7:0] CF = usbcs_pkg::ADDR_CFG;
  localparam logic [7:0] IS = usbcs_pkg::ADDR_IST;
  localparam logic [7:0] IM = usbcs_pkg::ADDR_IMSK;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] m;} usbcs_row_t;
  logic                  clock_i = 1'b0;
  logic                  rst_i   = 1'b1;
  logic                  psel    = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite  = 1'b0;
  logic [7:0]            paddr   = 8'h00;
  logic [31:0]           pwdata  = 32'h0;
  logic                  bus_rst = 1'b0;
  logic [3:0]            lat     = 4'h3;
  usbcs_pkg::usbcs_evt_t fire    = '0;
  usbcs_pkg::usbcs_evt_t evt;
  usbcs_pkg::usbcs_ctl_t ctl;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  irq;
  logic [31:0]           rdata;
  logic                  rerr;
  int                    n_errors  = 0;
  int                    cmp_count = 0;
  int                    n_go      = 0;
  int                    n_fl      = 0;
  int                    g0;
  int                    k;
  // Reads carry the expected value in d and the bits that matter in m.
  usbcs_row_t rows [6] = '{
    '{1'b0, G, 32'h0000_2000, 32'h0000_f800},
    '{1'b1, G, 32'h0000_4000, 32'h0},
    '{1'b0, G, 32'h0000_4000, 32'h0000_7800},
    '{1'b1, G, 32'h0000_4800, 32'h0},
    '{1'b0, G, 32'h0000_4000, 32'h0000_0800},
    '{1'b0, EP, 32'h0, 32'h0369_0000}};

  always #2 clock_i = ~clock_i;

  usbcs_top uut (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .bus_rst_line_i(bus_rst), .evt_i(evt), .ctl_o(ctl), .irq_o(irq));

  usbcs_engine_model eng (.clock_i(clock_i), .rst_i(rst_i), .fire_i(fire), .lat_i(lat),
    .ctl_i(ctl), .evt_o(evt));

  always @(posedge clock_i) begin
    if (ctl.tx_go === 1'b1) n_go++;
    if (ctl.fifo_flush === 1'b1) n_fl++;
  end

  // ====================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h mask %h", $time, got, exp, m);
    end
  endtask

  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp}, 32'h1);
  endtask

  // Entered just after a rising edge; returns one idle edge after the completing edge, so that
  // outputs launched at the completing edge have settled and psel is never driven twice at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1, 32'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp, m);
  endtask

  task automatic ev(input usbcs_pkg::usbcs_evt_t e);
    fire <= e;
    @(posedge clock_i);
    fire <= '0;
    repeat (4) @(posedge clock_i);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  // ====================
  // Sequence
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rdata, rows[i].d, rows[i].m);
    end
    chb(ctl.line_oe, 1'b1);
    chb(ctl.hs_enable, 1'b0);
    apb(1'b1, G, 32'h0);
    chb(ctl.line_oe, 1'b0);
    apb(1'b0, 8'h14, 32'h0);
    chb(rerr, 1'b1);
    $display("Test table done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk({24'h0, ctl}, {24'h0, usbcs_pkg::CTL_RST}, 32'hff);
    chb(irq, 1'b0);
    $display("Test reset done");
    apb(1'b1, IM, 32'h2);
    ev('{tx_ep_evt: 7'h41, ep0_evt: 1'b1, default: '0});
    chb(irq, 1'b1);
    rd(G, 32'h0083_0000, 32'h00ff_0000);
    rd(G, 32'h0, 32'h00ff_0000);
    apb(1'b1, IS, 32'h2);
    chb(irq, 1'b0);
    ev('{tx_ep_evt: 7'h02, default: '0});
    chb(irq, 1'b0);
    rd(IS, 32'h1, 32'h1f);
    $display("Test events done");
    apb(1'b1, G, 32'h2000);
    bus_rst <= 1'b1;
    repeat (6) @(posedge clock_i);
    rd(G, 32'h0800, 32'h0800);
    fire.hs_ok <= 1'b1;
    bus_rst <= 1'b0;
    repeat (6) @(posedge clock_i);
    fire <= '0;
    rd(G, 32'h1000, 32'h1800);
    apb(1'b1, EP, 32'h0020_0000);
    chb(ctl.stall_hs, 1'b1);
    ev('{stall_sent: 1'b1, default: '0});
    rd(EP, 32'h0060_0000, 32'h0060_0000);
    rd(EP, 32'h0060_0000, 32'h0060_0000);
    apb(1'b1, EP, 32'h0);
    chb(ctl.stall_hs, 1'b0);
    rd(EP, 32'h0, 32'h0060_0000);
    $display("Test device done");
    apb(1'b1, CF, 32'h2);
    apb(1'b1, G, 32'h0000_a000);
    g0 = n_go;
    ev('{tx_rdy: 1'b1, default: '0});
    chk(n_go, g0, 32'hff);
    ev('{sof: 1'b1, default: '0});
    chk(n_go, g0 + 1, 32'hff);
    apb(1'b1, G, 32'h2000);
    ev('{tx_rdy: 1'b1, default: '0});
    chk(n_go, g0 + 2, 32'hff);
    ev('{rx_incomplete: 1'b1, rx_rdy: 1'b1, rx_crc_err: 1'b1, default: '0});
    rd(EP, 32'h0109_0000, 32'h0109_0000);
    apb(1'b1, EP, 32'h0);
    rd(EP, 32'h0, 32'h0109_0000);
    apb(1'b1, CF, 32'h4);
    ev('{rx_incomplete: 1'b1, rx_rdy: 1'b1, rx_crc_err: 1'b1, default: '0});
    rd(EP, 32'h0001_0000, 32'h0109_0000);
    g0 = n_fl;
    apb(1'b1, EP, 32'h0011_0000);
    repeat (2) @(posedge clock_i);
    chk(n_fl, g0 + 1, 32'hff);
    rd(EP, 32'h0, 32'h0011_0000);
    $display("Test iso done");
    apb(1'b1, CF, 32'h5);
    apb(1'b1, G, 32'h0800);
    chb(ctl.drive_reset, 1'b1);
    rd(G, 32'h0800, 32'h0800);
    apb(1'b1, G, 32'h0);
    chb(ctl.drive_reset, 1'b0);
    apb(1'b1, EP, 32'h0200_0000);
    chb(ctl.data_toggle, 1'b0);
    apb(1'b1, EP, 32'h0600_0000);
    chb(ctl.data_toggle, 1'b1);
    rd(EP, 32'h0200_0000, 32'h0200_0000);
    apb(1'b1, EP, 32'h0);
    chb(ctl.data_toggle, 1'b1);
    apb(1'b1, EP, 32'h0680_0000);
    chb(ctl.data_toggle, 1'b0);
    apb(1'b1, IM, 32'h4);
    ev('{stall_rcvd: 1'b1, default: '0});
    rd(EP, 32'h0040_0000, 32'h0040_0000);
    chb(irq, 1'b1);
    apb(1'b1, EP, 32'h0);
    rd(EP, 32'h0, 32'h0040_0000);
    apb(1'b1, IS, 32'h4);
    chb(irq, 1'b0);
    apb(1'b1, EP, 32'h0020_0000);
    chb(ctl.in_request, 1'b1);
    k = 0;
    while (ctl.in_request !== 1'b0 && k < 30) begin
      @(posedge clock_i);
      k++;
    end
    chb(k < 30, 1'b1);
    rd(EP, 32'h0001_0000, 32'h0021_0000);
    ev('{nak_timeout: 1'b1, default: '0});
    rd(EP, 32'h0008_0000, 32'h0008_0000);
    $display("Test host done");
    summarize();
  end
endmodule // testbench
